// ---- pkg/lbr_pkg.sv ----
/*
  Shared types and constants for the burst read path: register map,
  command codes, burst geometry and strobe patterns.
  Assumes a 32-bit register port and a x16 data lane pair per link cycle.
*/
package lbr_pkg;

  // Register map, byte addresses
  localparam logic [7:0]  CFG_ADDR    = 8'h00;
  localparam logic [7:0]  STATUS_ADDR = 8'h04;
  localparam logic [7:0]  COUNT_ADDR  = 8'h08;

  // Field positions in the configuration and status words
  localparam int          CFG_RL_LSB    = 0;
  localparam int          CFG_TOG_BIT   = 8;
  localparam int          CFG_EXT_BIT   = 9;
  localparam int          STAT_ERR_BIT  = 16;
  localparam int          STAT_PEND_BIT = 17;

  // Command codes on the first edge of each two-edge command
  localparam logic [4:0]  CODE_READ1 = 5'h02;
  localparam logic [4:0]  CODE_WRITE1 = 5'h04;
  localparam logic [4:0]  CODE_CAS2  = 5'h12;

  // Latency and burst geometry, in link clock cycles
  localparam logic [5:0]  RL_MIN     = 6'h03;
  localparam logic [5:0]  RL_RST     = 6'h0e;
  localparam int          SLOT_DEPTH = 64;
  localparam int          PRE_CYC    = 2;
  localparam logic [3:0]  BL16_LAST  = 4'h7;
  localparam logic [3:0]  BL32_LAST  = 4'hf;

  // Strobe half-cycle patterns, bit 0 is the first half of a cycle
  localparam logic [1:0]  DQS_DATA   = 2'h1;
  localparam logic [1:0]  DQS_TOGGLE = 2'h1;
  localparam logic [1:0]  DQS_STATIC = 2'h0;
  localparam logic [1:0]  DQS_EXTPST = 2'h2;
  localparam logic [1:0]  OE_BOTH    = 2'h3;
  localparam logic [1:0]  OE_FIRST   = 2'h1;
  localparam logic [1:0]  OE_NONE    = 2'h0;

  typedef struct packed {
    logic [5:0] rl;
    logic       tog_pre;
    logic       ext_post;
  } lbr_cfg_s;

  localparam lbr_cfg_s    CFG_RST = '{rl: RL_RST, tog_pre: 1'b1, ext_post: 1'b0};

  typedef struct packed {
    logic       is_read;
    logic       bl32;
    logic [2:0] bank;
    logic [9:0] col;
  } lbr_cmd_s;

  typedef struct packed {
    logic       valid;
    logic       bl32;
    logic [2:0] bank;
    logic [9:0] col;
  } lbr_slot_s;

endpackage

// ---- hdl/lbr_sync2.sv ----
/*
  Two-flop synchroniser for levels and toggles, one lane per bit.
  Assumes each bit is a level that is stable long enough to be seen.
*/
`timescale 1ns/10ps
module lbr_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_o      <= meta_reg;
  end

endmodule

// ---- hdl/lbr_cmd_decode.sv ----
/*
  Command bus decoder on the link clock: assembles a READ-1 or WRITE-1
  pair followed by a CAS-2 pair into one column command.
  Assumes chip select and command lines are timed to the link clock.
*/
`timescale 1ns/10ps
module lbr_cmd_decode
  import lbr_pkg::*;
(
  input  wire logic       ck_i,
  input  wire logic       rst_n_i,
  input  wire logic       cke_i,
  input  wire logic       cs_i,
  input  wire logic [5:0] ca_i,
  output logic            cmd_v_o,
  output lbr_cmd_s        cmd_o
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_CMD_B = 4'h2,
    ST_WCAS  = 4'h4,
    ST_CAS_B = 4'h8
  } lbr_dec_e;

  lbr_dec_e state_reg;
  lbr_cmd_s hold_reg;

  // Clock-enable low freezes decoding; the host must keep it high
  always_ff @(posedge ck_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      hold_reg  <= '0;
      cmd_v_o   <= 1'b0;
      cmd_o     <= '0;
    end else begin
      cmd_v_o <= 1'b0;
      if (cke_i) begin
        case (state_reg)
          ST_IDLE: begin
            if (cs_i && (ca_i[4:0] == CODE_READ1 || ca_i[4:0] == CODE_WRITE1)) begin
              hold_reg.is_read <= (ca_i[4:0] == CODE_READ1);
              hold_reg.bl32    <= ca_i[5];
              state_reg        <= ST_CMD_B;
            end
          end
          ST_CMD_B: begin
            hold_reg.bank   <= ca_i[2:0];
            hold_reg.col[9] <= ca_i[4];
            state_reg       <= ST_WCAS;
          end
          ST_WCAS: begin
            if (cs_i && ca_i[4:0] == CODE_CAS2) begin
              hold_reg.col[8] <= ca_i[5];
              state_reg       <= ST_CAS_B;
            end else if (cs_i) begin
              state_reg <= ST_IDLE;
            end
          end
          ST_CAS_B: begin
            // Low column bits never travel, so bursts start on a 4-aligned column
            cmd_o     <= '{is_read: hold_reg.is_read, bl32: hold_reg.bl32,
                           bank: hold_reg.bank,
                           col: {hold_reg.col[9:8], ca_i, 2'b00}};
            cmd_v_o   <= 1'b1;
            state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// ---- hdl/lbr_read_path.sv ----
/*
  Burst read path: register port on clk_i, command decode, latency
  scheduling and strobe/data framing on the link clock ck_i.
  Assumes an external serialiser turns each cycle's two halves into
  double-rate pin activity and builds the complementary strobe.
// Summary of operation
// - Running bursts are never cut short
// - Each command carries its own burst length
// - Two-cycle read preamble, static or toggling
// - Postamble half cycle, or one and half
// - Column low two bits are always zero
// - Latency counts from the completing edge
// - First data one latency after completion
// - Strobe starts one preamble before data
// - One beat per strobe edge, edge-aligned
// - Reads every tCCD give gapless data
*/
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/10ps
module lbr_read_path
  import lbr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        ck_i,
  input  wire logic        cke_i,
  input  wire logic        cs_i,
  input  wire logic [5:0]  ca_i,
  output logic      [15:0] dq_rise_o,
  output logic      [15:0] dq_fall_o,
  output logic             dq_oe_o,
  output logic      [1:0]  dqs_o,
  output logic      [1:0]  dqs_oe_o
);

  // Core domain state
  lbr_cfg_s    cfg_reg;
  logic        cfg_tgl_reg;
  logic [15:0] rd_cnt_reg;
  logic [15:0] wr_cnt_reg;
  logic        err_reg;
  logic [3:0]  ev_s;
  logic [3:0]  ev_last_reg;
  logic [3:0]  ev_pulse;
  logic        cfg_pend;
  logic        err_next;

  // Link domain state
  logic        lrst_n;
  logic        cfg_tgl_s;
  logic        cfg_seen_reg;
  lbr_cfg_s    link_cfg_reg;
  logic        cmd_v;
  lbr_cmd_s    cmd;
  lbr_slot_s   slot_reg [SLOT_DEPTH];
  logic [5:0]  rl_eff;
  logic [5:0]  rl_idx;
  logic [3:0]  beat_reg;
  logic [3:0]  last_reg;
  logic [9:0]  col_reg;
  logic [2:0]  bank_reg;
  logic        pre_reg;
  logic        tail_reg;
  logic        active;
  logic        done_tgl_reg;
  logic        err_tgl_reg;
  logic        wr_tgl_reg;
  logic [9:0]  addr_r;
  logic [9:0]  addr_f;

  // Core side: configuration, counters and read-back

  assign ev_pulse = ev_s ^ ev_last_reg;
  assign cfg_pend = cfg_tgl_reg ^ ev_s[3];

  lbr_sync2 #(.WIDTH(4)) ev_sync (
    .clk_i (clk_i),
    .d_i   ({cfg_seen_reg, wr_tgl_reg, err_tgl_reg, done_tgl_reg}),
    .q_o   (ev_s)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ev_last_reg <= 4'h0;
    end else begin
      ev_last_reg <= ev_s;
    end
  end

  // New framing is refused until the link side has taken the last one
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_reg     <= CFG_RST;
      cfg_tgl_reg <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == CFG_ADDR && !cfg_pend) begin
      cfg_reg.rl       <= reg_wdata_i[CFG_RL_LSB +: 6];
      cfg_reg.tog_pre  <= reg_wdata_i[CFG_TOG_BIT];
      cfg_reg.ext_post <= reg_wdata_i[CFG_EXT_BIT];
      cfg_tgl_reg      <= ~cfg_tgl_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_cnt_reg <= 16'h0000;
      wr_cnt_reg <= 16'h0000;
    end else begin
      if (ev_pulse[0]) begin
        rd_cnt_reg <= rd_cnt_reg + 16'h0001;
      end
      if (ev_pulse[2]) begin
        wr_cnt_reg <= wr_cnt_reg + 16'h0001;
      end
    end
  end

  // A new overlap in the clearing cycle keeps the flag set
  always_comb begin
    err_next = err_reg;
    if (reg_wr_i && reg_addr_i == STATUS_ADDR && reg_wdata_i[STAT_ERR_BIT]) begin
      err_next = 1'b0;
    end
    if (ev_pulse[1]) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        CFG_ADDR:    reg_rdata_o <= {22'h00_0000, cfg_reg.ext_post, cfg_reg.tog_pre,
                                     2'b00, cfg_reg.rl};
        STATUS_ADDR: reg_rdata_o <= {14'h0000, cfg_pend, err_reg, 16'h0000};
        COUNT_ADDR:  reg_rdata_o <= {wr_cnt_reg, rd_cnt_reg};
        default:     reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  cfg_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == CFG_ADDR && cfg_pend |=> $stable(cfg_reg))
    else $error("framing changed while a previous update was in flight");

  err_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ev_pulse[1] |=> err_reg)
    else $error("overlap event lost");

  // Link side: reset, configuration capture, decode

  lbr_sync2 #(.WIDTH(2)) link_sync (
    .clk_i (ck_i),
    .d_i   ({cfg_tgl_reg, rst_n_i}),
    .q_o   ({cfg_tgl_s, lrst_n})
  );

  // The core holds the framing word steady until the toggle is echoed
  always_ff @(posedge ck_i) begin
    if (!lrst_n) begin
      cfg_seen_reg <= 1'b0;
      link_cfg_reg <= CFG_RST;
    end else if (cfg_tgl_s != cfg_seen_reg) begin
      cfg_seen_reg <= cfg_tgl_s;
      link_cfg_reg <= cfg_reg;
    end
  end

  lbr_cmd_decode cmd_dec (
    .ck_i    (ck_i),
    .rst_n_i (lrst_n),
    .cke_i   (cke_i),
    .cs_i    (cs_i),
    .ca_i    (ca_i),
    .cmd_v_o (cmd_v),
    .cmd_o   (cmd)
  );

  // Latencies not above the preamble span would leave no room for it
  assign rl_eff = (link_cfg_reg.rl < RL_MIN) ? RL_MIN : link_cfg_reg.rl;
  assign rl_idx = rl_eff - 6'h02;

  // Timeline: slot k fires k edges later; slot 0 starts data
  always_ff @(posedge ck_i) begin
    if (!lrst_n) begin
      for (int i = 0; i < SLOT_DEPTH; i++) begin
        slot_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < SLOT_DEPTH - 1; i++) begin
        slot_reg[i] <= slot_reg[i+1];
      end
      slot_reg[SLOT_DEPTH-1] <= '0;
      if (cmd_v && cmd.is_read) begin
        slot_reg[rl_idx] <= '{valid: 1'b1, bl32: cmd.bl32,
                              bank: cmd.bank, col: cmd.col};
      end
    end
  end

  // Burst engine and strobe framing

  assign active = dq_oe_o && (beat_reg != last_reg);
  assign addr_r = col_reg + {5'h00, beat_reg, 1'b0};
  assign addr_f = col_reg + {5'h00, beat_reg, 1'b1};

  always_ff @(posedge ck_i) begin
    if (!lrst_n) begin
      beat_reg  <= 4'h0;
      last_reg  <= BL16_LAST;
      col_reg   <= 10'h000;
      bank_reg  <= 3'h0;
      dq_oe_o   <= 1'b0;
      dqs_o     <= DQS_STATIC;
      dqs_oe_o  <= OE_NONE;
      pre_reg   <= 1'b0;
      tail_reg  <= 1'b0;
    end else begin
      pre_reg  <= 1'b0;
      tail_reg <= 1'b0;
      if (active) begin
        beat_reg <= beat_reg + 4'h1;
        dqs_o    <= DQS_DATA;
        dqs_oe_o <= OE_BOTH;
      end else if (slot_reg[0].valid) begin
        // Lands on the last beat of a prior burst when reads are tCCD apart
        beat_reg <= 4'h0;
        last_reg <= slot_reg[0].bl32 ? BL32_LAST : BL16_LAST;
        col_reg  <= slot_reg[0].col;
        bank_reg <= slot_reg[0].bank;
        dq_oe_o  <= 1'b1;
        dqs_o    <= DQS_DATA;
        dqs_oe_o <= OE_BOTH;
      end else if (slot_reg[1].valid || slot_reg[2].valid
                   || (cmd_v && cmd.is_read && rl_idx == 6'h01)) begin
        dq_oe_o  <= 1'b0;
        pre_reg  <= 1'b1;
        dqs_o    <= link_cfg_reg.tog_pre ? DQS_TOGGLE : DQS_STATIC;
        dqs_oe_o <= OE_BOTH;
      end else if (dq_oe_o) begin
        dq_oe_o  <= 1'b0;
        tail_reg <= link_cfg_reg.ext_post;
        dqs_o    <= link_cfg_reg.ext_post ? DQS_EXTPST : DQS_STATIC;
        dqs_oe_o <= link_cfg_reg.ext_post ? OE_BOTH : OE_FIRST;
      end else if (tail_reg) begin
        dqs_o    <= DQS_STATIC;
        dqs_oe_o <= OE_FIRST;
      end else begin
        dqs_o    <= DQS_STATIC;
        dqs_oe_o <= OE_NONE;
      end
    end
  end

  // Beat pair per cycle: rising half then falling half
  always_ff @(posedge ck_i) begin
    if (!lrst_n) begin
      dq_rise_o <= 16'h0000;
      dq_fall_o <= 16'h0000;
    end else if (active) begin
      dq_rise_o <= {bank_reg, 3'b000, addr_r + 10'h002};
      dq_fall_o <= {bank_reg, 3'b000, addr_f + 10'h002};
    end else if (slot_reg[0].valid) begin
      dq_rise_o <= {slot_reg[0].bank, 3'b000, slot_reg[0].col};
      dq_fall_o <= {slot_reg[0].bank, 3'b000, slot_reg[0].col + 10'h001};
    end else begin
      dq_rise_o <= 16'h0000;
      dq_fall_o <= 16'h0000;
    end
  end

  // Events toward the core; an early read is dropped, not spliced in
  always_ff @(posedge ck_i) begin
    if (!lrst_n) begin
      done_tgl_reg <= 1'b0;
      err_tgl_reg  <= 1'b0;
      wr_tgl_reg   <= 1'b0;
    end else begin
      if (dq_oe_o && !active) begin
        done_tgl_reg <= ~done_tgl_reg;
      end
      if (active && slot_reg[0].valid) begin
        err_tgl_reg <= ~err_tgl_reg;
      end
      if (cmd_v && !cmd.is_read) begin
        wr_tgl_reg <= ~wr_tgl_reg;
      end
    end
  end

  sched_slot_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    cmd_v && cmd.is_read |=> slot_reg[$past(rl_idx)].valid)
    else $error("read not scheduled at its latency slot");

  data_start_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    slot_reg[0].valid && !active |=> dq_oe_o && beat_reg == 4'h0)
    else $error("burst did not start when its slot fired");

  col_align_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    dq_oe_o && beat_reg == 4'h0 |-> dq_rise_o[1:0] == 2'b00)
    else $error("burst start column not a multiple of four");

  edge_align_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    dq_oe_o |-> dqs_o == DQS_DATA && dqs_oe_o == OE_BOTH
             && dq_fall_o[9:0] == dq_rise_o[9:0] + 10'h001)
    else $error("data beats not paired with strobe edges");

  no_cut_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    active |=> dq_oe_o && beat_reg == $past(beat_reg) + 4'h1)
    else $error("running burst interrupted");

  burst_len_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    slot_reg[0].valid && !active
      |=> last_reg == ($past(slot_reg[0].bl32) ? BL32_LAST : BL16_LAST))
    else $error("burst length does not follow the command");

  pre_len_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    $rose(dq_oe_o) |-> $past(dqs_oe_o, 1) == OE_BOTH && $past(dqs_oe_o, 2) == OE_BOTH)
    else $error("strobe not driven for two cycles before data");

  pre_kind_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    pre_reg |-> dqs_o == ($past(link_cfg_reg.tog_pre) ? DQS_TOGGLE : DQS_STATIC))
    else $error("preamble pattern does not follow the mode");

  post_std_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    $fell(dq_oe_o) && !pre_reg && !$past(link_cfg_reg.ext_post)
      |-> dqs_oe_o == OE_FIRST && dqs_o[0] == 1'b0)
    else $error("standard postamble wrong");

  post_ext_a: assert property (@(posedge ck_i) disable iff (!lrst_n)
    $fell(dq_oe_o) && !pre_reg && $past(link_cfg_reg.ext_post)
      |-> dqs_oe_o == OE_BOTH && dqs_o == DQS_EXTPST)
    else $error("extended postamble wrong");

endmodule

// ---- bench/lbr_host_model.sv ----
/*
  Host controller model: drives the two-edge column commands on the link
  command bus, timed to rising edges of the link clock.
  Assumes the bench makes ck_i and calls issue() only after reset.
*/
`timescale 1ns/10ps
module lbr_host_model
  import lbr_pkg::*;
(
  input  wire logic       ck_i,
  output logic            cke_o,
  output logic            cs_o,
  output logic      [5:0] ca_o
);
  logic busy;

  initial begin
    cke_o = 1'b1;
    cs_o  = 1'b0;
    ca_o  = 6'h2a;
    busy  = 1'b0;
  end

  // Deselected lines wander, so a stale value never passes for a command
  always @(posedge ck_i) begin
    if (!busy) begin
      ca_o <= ~ca_o;
    end
  end

  // Banks taken as open; cs and ca change only after rising edges
  // Length chosen per command, 16 or 32 beats
  // Caller programs framing first and spaces writes after reads
  // Strobe never sampled here, so its state before the preamble is moot
  task automatic issue(input logic rd, input logic bl32, input logic [2:0] bank,
                       input logic [9:0] col);
    busy = 1'b1;
    @(posedge ck_i);
    cs_o <= 1'b1;
    ca_o <= {bl32, (rd ? CODE_READ1 : CODE_WRITE1)};
    @(posedge ck_i);
    cs_o <= 1'b0;
    ca_o <= {1'b0, col[9], 1'b0, bank};
    @(posedge ck_i);
    cs_o <= 1'b1;
    ca_o <= {col[8], CODE_CAS2};
    @(posedge ck_i);
    cs_o <= 1'b0;
    ca_o <= col[7:2];
    @(posedge ck_i);
    busy = 1'b0;
  endtask
endmodule

// ---- bench/testbench.sv ----
/*
  Self-checking bench for the burst read path: register port, read
  framing, gapless and overlapping reads, reset in mid-burst.
  Assumes the host model drives the command bus on the 15 ns link clock.
*/
`timescale 1ns/10ps
module testbench;
  import lbr_pkg::*;

  typedef struct packed {
    logic [5:0] rl;
    logic       tog;
    logic       ext;
    logic       bl32;
    logic [2:0] bank;
    logic [9:0] col;
  } lbr_row_s;

  logic        clk_i;
  logic        ck_i;
  logic        rst_n_i;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        cke;
  logic        cs;
  logic [5:0]  ca;
  logic [15:0] dq_rise;
  logic [15:0] dq_fall;
  logic        dq_oe;
  logic [1:0]  dqs;
  logic [1:0]  dqs_oe;
  logic [4:0]  obs;
  int          failures;
  int          compares;
  int          nrd;
  lbr_row_s    rows [6];
  lbr_row_s    ra;
  lbr_row_s    rb;

  assign obs = {dqs_oe, dqs & dqs_oe, dq_oe};

  lbr_read_path lbr_read_path_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .ck_i(ck_i), .cke_i(cke), .cs_i(cs), .ca_i(ca), .dq_rise_o(dq_rise), .dq_fall_o(dq_fall),
    .dq_oe_o(dq_oe), .dqs_o(dqs), .dqs_oe_o(dqs_oe));

  lbr_host_model lbr_host_model_inst (.ck_i(ck_i), .cke_o(cke), .cs_o(cs), .ca_o(ca));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Link clock offset so its edges never line up with the core clock
  initial begin
    ck_i = 1'b0;
    #3.7;
    forever #7.5 ck_i = ~ck_i;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask

  // New framing only lands once the pending flag drops
  task automatic set_cfg(input lbr_row_s r);
    logic [31:0] d;
    int          i;
    wr(CFG_ADDR, {22'h0, r.ext, r.tog, 2'b00, r.rl});
    d = 32'h0002_0000;
    i = 0;
    while (d[STAT_PEND_BIT] !== 1'b0 && i < 40) begin
      rd(STATUS_ADDR, d);
      i++;
    end
    chk("config pending", 32'h0, {31'h0, d[STAT_PEND_BIT]});
  endtask

  // Walks from the completing edge; pre=0 skips lead-in, tail=0 skips postamble
  task automatic check_burst(input lbr_row_s r, input bit pre, input bit tail);
    int         erl;
    int         cyc;
    int         last;
    int         m;
    logic [9:0] c0;
    logic [3:0] pst;
    erl  = (r.rl < 6'h03) ? 3 : int'(r.rl);
    cyc  = r.bl32 ? 16 : 8;
    last = tail ? erl + cyc + 2 : erl + cyc - 1;
    c0   = {r.col[9:2], 2'b00};
    for (int n = 1; n <= last; n++) begin
      @(posedge ck_i);
      #1;
      if (n < erl - 2) begin
        if (pre) chk("idle strobe", 32'h0, 32'(obs));
      end else if (n < erl) begin
        if (pre) chk("preamble", {27'h0, 3'b110, r.tog, 1'b0}, 32'(obs));
      end else if (n < erl + cyc) begin
        m = n - erl;
        chk("data strobe", 32'h0000_001b, 32'(obs));
        chk("data", {r.bank, 3'b000, c0 + 10'(2 * m), r.bank, 3'b000, c0 + 10'(2 * m + 1)},
            {dq_rise, dq_fall});
      end else begin
        m   = n - erl - cyc;
        pst = r.ext ? ((m == 0) ? 4'b1110 : (m == 1) ? 4'b0100 : 4'b0000)
                    : ((m == 0) ? 4'b0100 : 4'b0000);
        chk("postamble", {27'h0, pst, 1'b0}, 32'(obs));
      end
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run is a few hundred link cycles; this is far beyond it
  initial begin
    #400000;
    failures++;
    give_verdict();
  end

  initial begin
    rst_n_i   = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    failures  = 0;
    compares  = 0;
    nrd       = 0;
    rows[0] = '{6'h0e, 1'b1, 1'b0, 1'b0, 3'h3, 10'h010};
    rows[1] = '{6'h0e, 1'b0, 1'b1, 1'b1, 3'h5, 10'h3f0};
    rows[2] = '{6'h03, 1'b1, 1'b1, 1'b0, 3'h7, 10'h104};
    rows[3] = '{6'h01, 1'b0, 1'b0, 1'b1, 3'h0, 10'h3ff};
    rows[4] = '{6'h14, 1'b1, 1'b1, 1'b1, 3'h2, 10'h200};
    rows[5] = '{6'h04, 1'b0, 1'b0, 1'b0, 3'h1, 10'h0a8};
    // Held past four link edges, since the link reset lags by two
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge ck_i);
    rdc("cfg reset", CFG_ADDR, 32'h0000_010e);
    rdc("status reset", STATUS_ADDR, 32'h0000_0000);
    rdc("count reset", COUNT_ADDR, 32'h0000_0000);
    wr(8'h0c, 32'hffff_ffff);
    rdc("unmapped", 8'h0c, 32'h0000_0000);
    rdc("cfg kept", CFG_ADDR, 32'h0000_010e);
    for (int i = 0; i < 6; i++) begin
      set_cfg(rows[i]);
      lbr_host_model_inst.issue(1'b1, rows[i].bl32, rows[i].bank, rows[i].col);
      check_burst(rows[i], 1'b1, 1'b1);
      nrd++;
    end
    // Reads one burst apart must join without a gap
    ra = '{6'h04, 1'b0, 1'b0, 1'b0, 3'h1, 10'h040};
    rb = '{6'h04, 1'b0, 1'b0, 1'b0, 3'h6, 10'h080};
    lbr_host_model_inst.issue(1'b1, ra.bl32, ra.bank, ra.col);
    fork
      check_burst(ra, 1'b1, 1'b0);
      begin
        repeat (3) @(posedge ck_i);
        lbr_host_model_inst.issue(1'b1, rb.bl32, rb.bank, rb.col);
        check_burst(rb, 1'b0, 1'b1);
      end
    join
    nrd += 2;
    // A read landing mid-burst is dropped; the running burst stays whole
    lbr_host_model_inst.issue(1'b1, ra.bl32, ra.bank, ra.col);
    fork
      check_burst(ra, 1'b1, 1'b1);
      lbr_host_model_inst.issue(1'b1, rb.bl32, rb.bank, rb.col);
    join
    nrd++;
    rdc("overlap flag", STATUS_ADDR, 32'h0001_0000);
    wr(STATUS_ADDR, 32'h0001_0000);
    rdc("overlap cleared", STATUS_ADDR, 32'h0000_0000);
    lbr_host_model_inst.issue(1'b0, 1'b0, 3'h4, 10'h020);
    repeat (20) @(posedge clk_i);
    rdc("counts", COUNT_ADDR, {16'h0001, 16'(nrd)});
    // Second write arrives while the first is still pending
    wr(CFG_ADDR, 32'h0000_0314);
    wr(CFG_ADDR, 32'h0000_0005);
    rdc("cfg refused", CFG_ADDR, 32'h0000_0314);
    set_cfg(rows[4]);
    lbr_host_model_inst.issue(1'b1, 1'b1, 3'h2, 10'h100);
    repeat (24) @(posedge ck_i);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    chk("reset outputs", 32'h0, {11'h0, obs, dq_rise});
    chk("reset rdata", 32'h0, reg_rdata);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge ck_i);
    rdc("cfg after reset", CFG_ADDR, 32'h0000_010e);
    rdc("count after reset", COUNT_ADDR, 32'h0000_0000);
    lbr_host_model_inst.issue(1'b1, rows[0].bl32, rows[0].bank, rows[0].col);
    check_burst(rows[0], 1'b1, 1'b1);
    give_verdict();
  end
endmodule
